// File: include/node_init_params.svh
// Constants for the node-address initialization and recovery block.
// Assumes a 50 MHz system clock and a 24-bit SPI frame sampled in that clock.
`ifndef NODE_INIT_PARAMS_SVH
`define NODE_INIT_PARAMS_SVH

// Timing.
`define CLK_PERIOD_NS    20
`define READY_TIME_US    1000
`define SENSE_TIME_NS    10000
`define SENSE_CYCLES     (`SENSE_TIME_NS / `CLK_PERIOD_NS)
`define TIMER_W          24

// Frame layout: write flag, node address, register address, data.
`define FRAME_BITS       5'd24
`define FRM_WRITE_BIT    23
`define FRM_NODE_MSB     22
`define FRM_NODE_LSB     21
`define FRM_REG_MSB      20
`define FRM_REG_LSB      16
`define ADDR_SEEN_BITS   5'd2

// Register addresses.
`define REG_PRIMARY      5'h00
`define REG_SECONDARY    5'h01
`define REG_BROADCAST    5'h1E

// Broadcast command fields.
`define BC_CLR_FAULT_BIT 15
`define BC_REINIT_BIT    14
`define BC_OVERRIDE_BIT  13
`define BC_ASSIGN_MSB    12
`define BC_ASSIGN_LSB    11

// Reply flag positions.
`define RPL_SUPPLY_BIT   20
`define RPL_ADDRERR_BIT  19
`define RPL_NOTRDY_BIT   18
`define RPL_NODE_MSB     17
`define RPL_NODE_LSB     16

`endif

// File: include/node_init_pkg.sv
// Types shared by the node-address initialization block.
// Assumes nothing of its surroundings.
package node_init_pkg;
  typedef enum logic [2:0] {
    ST_SUPPLY_WAIT,
    ST_READY_WAIT,
    ST_SENSE,
    ST_SECOND_INIT_STATE
  } init_state_t;
endpackage

// File: hw/cycle_timer.sv
// Down-counting one-shot timer with a registered done pulse.
// Assumes start is a one-cycle pulse and load is nonzero.
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
  parameter int W = 24
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Control.
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  // Status.
  output logic              busy,
  output logic              done
);
  logic [W-1:0] count_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (start) begin
      count_r <= load;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
    end else begin
      done <= (count_r == W'(1)) && !start;
    end
  end

  assign busy = (count_r != '0);
endmodule
`default_nettype wire

// File: hw/node_addr_init.sv
// Power-up node-address initialization and recovery with its SPI slave.
// Assumes all pins are synchronous to clk; sclk is idle low, sampled on its rise.
`include "node_init_params.svh"
`timescale 1ns/10ps
`default_nettype none
module node_addr_init #(
  parameter int READY_CYCLES = `READY_TIME_US * 1000 / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Supply monitors, internal error and config CRC warning.
  input  wire logic       hvSupplyUndervoltage,
  input  wire logic       logicSupplyOvervoltage,
  input  wire logic       logicSupplyUndervoltage,
  input  wire logic       deviceError,
  input  wire logic       configCrcWarning,
  // Fault/address pin and its sensing front end.
  input  wire logic       faultAddressPinIn,
  output logic            faultAddressPinOut,
  output logic            faultAddressPinOe,
  input  wire logic [1:0] senseCode,
  // Enable pins.
  input  wire logic       enablePinOne,
  input  wire logic       enablePinTwo,
  // SPI.
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       sdi,
  input  wire logic       sdoIn,
  output logic            sdoOut,
  output logic            sdoOe,
  // Status.
  output logic [1:0]      nodeAddress,
  output logic            nodeAddressError,
  output logic            secondInitState
);
  node_init_pkg::init_state_t state_r;
  logic [23:0] shiftIn_r, reply_r, txWord_r;
  logic [4:0]  bitCnt_r;
  logic        sclkPrev_r, csPrev_r, addrMatch_r, backOff_r, sdoOe_r, dead_r;
  logic        por_r, pinStatValid_r, reinitPend_r, addrErr_r;
  logic [1:0]  nodeAddr_r;
  logic        sclkRise, sclkFall, frameStart, frameEnd, frameOk, supplyErr, notReady;
  logic        isWrite, isBcWrite, addressed, conflict, reinitAcc, reinitRun, overrideAcc;
  logic        readyStart, readyDone, senseStart, senseDone;
  logic [4:0]  regAddr;
  logic [15:0] replyData;

  assign sclkRise   = sclk && !sclkPrev_r;
  assign sclkFall   = !sclk && sclkPrev_r;
  assign frameStart = !csN && csPrev_r;
  assign frameEnd   = csN && !csPrev_r;
  assign frameOk    = frameEnd && (bitCnt_r == `FRAME_BITS);
  assign regAddr    = shiftIn_r[`FRM_REG_MSB:`FRM_REG_LSB];
  assign isWrite    = shiftIn_r[`FRM_WRITE_BIT];
  assign isBcWrite  = frameOk && isWrite && (regAddr == `REG_BROADCAST);
  assign addressed  = shiftIn_r[`FRM_NODE_MSB:`FRM_NODE_LSB] == nodeAddr_r;
  assign supplyErr  = hvSupplyUndervoltage || logicSupplyOvervoltage || logicSupplyUndervoltage;
  assign notReady   = (state_r != node_init_pkg::ST_SECOND_INIT_STATE);
  assign conflict   = sdoOe_r && (sdoIn != txWord_r[23]);

  ////////////////////////////////////////////////////////////////////////////////
  // Initialization sequence.

  assign reinitAcc   = isBcWrite && (state_r == node_init_pkg::ST_SECOND_INIT_STATE);
  assign reinitRun   = reinitAcc && !shiftIn_r[`BC_REINIT_BIT] && reinitPend_r;
  assign overrideAcc = reinitAcc && addrErr_r && !shiftIn_r[`BC_REINIT_BIT]
                       && shiftIn_r[`BC_OVERRIDE_BIT];
  assign readyStart  = (state_r == node_init_pkg::ST_SUPPLY_WAIT) && !supplyErr;
  assign senseStart  = ((state_r == node_init_pkg::ST_READY_WAIT) && readyDone && !supplyErr)
                       || reinitRun;

  cycle_timer #(.W(`TIMER_W)) readyTimer (
    .clk   (clk),
    .srst  (srst),
    .start (readyStart),
    .load  (`TIMER_W'(READY_CYCLES)),
    .busy  (),
    .done  (readyDone)
  );

  cycle_timer #(.W(`TIMER_W)) senseTimer (
    .clk   (clk),
    .srst  (srst),
    .start (senseStart),
    .load  (`TIMER_W'(`SENSE_CYCLES)),
    .busy  (),
    .done  (senseDone)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= node_init_pkg::ST_SUPPLY_WAIT;
    end else begin
      case (state_r)
        node_init_pkg::ST_SUPPLY_WAIT: begin
          if (!supplyErr) state_r <= node_init_pkg::ST_READY_WAIT;
        end
        node_init_pkg::ST_READY_WAIT: begin
          if (supplyErr) state_r <= node_init_pkg::ST_SUPPLY_WAIT;
          else if (readyDone) state_r <= node_init_pkg::ST_SENSE;
        end
        node_init_pkg::ST_SENSE: begin
          if (senseDone) state_r <= node_init_pkg::ST_SECOND_INIT_STATE;
        end
        node_init_pkg::ST_SECOND_INIT_STATE: begin
          if (reinitRun) state_r <= node_init_pkg::ST_SENSE;
        end
        default: state_r <= node_init_pkg::ST_SUPPLY_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reinitPend_r <= 1'b0;
    end else if (reinitAcc) begin
      reinitPend_r <= shiftIn_r[`BC_REINIT_BIT];
    end
  end

  // Address error: setting events win over the override clear in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      addrErr_r  <= 1'b0;
      nodeAddr_r <= 2'h0;
    end else begin
      if (overrideAcc) begin
        nodeAddr_r <= shiftIn_r[`BC_ASSIGN_MSB:`BC_ASSIGN_LSB];
        addrErr_r  <= 1'b0;
      end
      if (senseDone) begin
        if (faultAddressPinIn) nodeAddr_r <= senseCode;
        addrErr_r <= !faultAddressPinIn;
      end
      if (conflict) addrErr_r <= 1'b1;
    end
  end

  // Only a power cycle, seen here as reset, releases a dead device.
  always_ff @(posedge clk) begin
    if (srst) begin
      dead_r            <= 1'b0;
      faultAddressPinOe <= 1'b0;
    end else begin
      if (deviceError) dead_r <= 1'b1;
      faultAddressPinOe <= dead_r || deviceError;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      por_r          <= 1'b1;
      pinStatValid_r <= 1'b0;
    end else begin
      if (isBcWrite && shiftIn_r[`BC_CLR_FAULT_BIT]) por_r <= 1'b0;
      if (frameOk && !isWrite && addressed && regAddr == `REG_PRIMARY) pinStatValid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // SPI receive, reply and transmit.

  always_ff @(posedge clk) begin
    if (srst) begin
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b1;
      bitCnt_r   <= 5'h00;
      shiftIn_r  <= 24'h000000;
    end else begin
      sclkPrev_r <= sclk;
      csPrev_r   <= csN;
      if (frameStart) begin
        bitCnt_r <= 5'h00;
      end else if (sclkRise && !csN) begin
        shiftIn_r <= {shiftIn_r[22:0], sdi};
        if (bitCnt_r != 5'h1F) bitCnt_r <= bitCnt_r + 5'h01;
      end
    end
  end

  // Primary status holds zero enable fields until it has been read once.
  always_comb begin
    replyData = 16'h0000;
    if (isWrite) begin
      replyData = shiftIn_r[15:0];
    end else if (regAddr == `REG_PRIMARY) begin
      replyData = {por_r, configCrcWarning, enablePinOne && pinStatValid_r,
                   enablePinTwo && pinStatValid_r, 7'h00, regAddr};
    end else if (regAddr == `REG_SECONDARY) begin
      replyData = {enablePinOne, 15'h0000};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reply_r <= 24'h000000;
    end else if (frameOk) begin
      reply_r <= {3'h0, supplyErr, addrErr_r, notReady, nodeAddr_r, replyData};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      txWord_r    <= 24'h000000;
      addrMatch_r <= 1'b0;
      backOff_r   <= 1'b0;
      sdoOe_r     <= 1'b0;
    end else begin
      if (frameStart) begin
        txWord_r    <= reply_r;
        addrMatch_r <= 1'b0;
        backOff_r   <= 1'b0;
      end else if (sclkFall && !csN) begin
        txWord_r <= {txWord_r[22:0], 1'b0};
      end
      if (sclkRise && !csN && bitCnt_r == `ADDR_SEEN_BITS) begin
        addrMatch_r <= ({shiftIn_r[0], sdi} == nodeAddr_r);
      end
      if (conflict) backOff_r <= 1'b1;
      sdoOe_r <= !csN && !frameStart && addrMatch_r && !backOff_r && !conflict
                 && !dead_r && !deviceError;
    end
  end

  assign sdoOut             = txWord_r[23];
  assign sdoOe              = sdoOe_r;
  assign faultAddressPinOut = 1'b0;
  assign nodeAddress        = nodeAddr_r;
  assign nodeAddressError   = addrErr_r;
  assign secondInitState    = (state_r == node_init_pkg::ST_SECOND_INIT_STATE);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_supplyGate;
    @(posedge clk) disable iff (srst)
    (state_r == node_init_pkg::ST_SUPPLY_WAIT && supplyErr) |=>
      state_r == node_init_pkg::ST_SUPPLY_WAIT;
  endproperty
  a_supplyGate: assert property (p_supplyGate) else $error("init left supply wait early");

  property p_notReady;
    @(posedge clk) disable iff (srst)
    (frameOk && state_r != node_init_pkg::ST_SECOND_INIT_STATE) |=> reply_r[`RPL_NOTRDY_BIT];
  endproperty
  a_notReady: assert property (p_notReady) else $error("reply not marked not-ready");

  property p_supplyFlag;
    @(posedge clk) disable iff (srst)
    frameOk |=> reply_r[`RPL_SUPPLY_BIT] == $past(supplyErr);
  endproperty
  a_supplyFlag: assert property (p_supplyFlag) else $error("supply flag wrong");

  property p_deadDevice;
    @(posedge clk) disable iff (srst)
    deviceError |=> ##1 (faultAddressPinOe && !sdoOe_r)[*4];
  endproperty
  a_deadDevice: assert property (p_deadDevice) else $error("dead device still active");

  property p_conflict;
    @(posedge clk) disable iff (srst)
    conflict |=> addrErr_r && !sdoOe_r;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not handled");

  property p_onlyMatch;
    @(posedge clk) disable iff (srst)
    sdoOe_r |-> addrMatch_r && !csPrev_r && !dead_r;
  endproperty
  a_onlyMatch: assert property (p_onlyMatch) else $error("unaddressed node drove SDO");

  property p_reinitIgnored;
    @(posedge clk) disable iff (srst)
    (isBcWrite && state_r != node_init_pkg::ST_SECOND_INIT_STATE && !reinitPend_r) |=> !reinitPend_r;
  endproperty
  a_reinitIgnored: assert property (p_reinitIgnored) else $error("reinit taken outside init");

  property p_reinitRestart;
    @(posedge clk) disable iff (srst)
    reinitRun |=> state_r == node_init_pkg::ST_SENSE ##[1:600] state_r == node_init_pkg::ST_SECOND_INIT_STATE;
  endproperty
  a_reinitRestart: assert property (p_reinitRestart) else $error("reinit did not resense");

  property p_override;
    @(posedge clk) disable iff (srst)
    (overrideAcc && !conflict && !senseDone) |=>
      nodeAddr_r == $past(shiftIn_r[`BC_ASSIGN_MSB:`BC_ASSIGN_LSB]) && !addrErr_r;
  endproperty
  a_override: assert property (p_override) else $error("override not adopted");

  property p_overrideGuard;
    @(posedge clk) disable iff (srst)
    (!addrErr_r && !senseDone) |=> nodeAddr_r == $past(nodeAddr_r);
  endproperty
  a_overrideGuard: assert property (p_overrideGuard) else $error("address moved without error");

  property p_senseFail;
    @(posedge clk) disable iff (srst)
    (senseDone && !faultAddressPinIn) |=> addrErr_r;
  endproperty
  a_senseFail: assert property (p_senseFail) else $error("sense failure not flagged");

  property p_echo;
    @(posedge clk) disable iff (srst)
    (frameOk && isWrite) |=> reply_r[15:0] == $past(shiftIn_r[15:0])
      && reply_r[`RPL_ADDRERR_BIT] == $past(addrErr_r);
  endproperty
  a_echo: assert property (p_echo) else $error("command not echoed");

  property p_secondary;
    @(posedge clk) disable iff (srst)
    (frameOk && !isWrite && regAddr == `REG_SECONDARY) |=> reply_r[15] == $past(enablePinOne);
  endproperty
  a_secondary: assert property (p_secondary) else $error("enable one level wrong");

  property p_firstStatus;
    @(posedge clk) disable iff (srst)
    (frameOk && !isWrite && regAddr == `REG_PRIMARY && !pinStatValid_r) |=>
      reply_r[13:12] == 2'h0 && reply_r[15] == $past(por_r);
  endproperty
  a_firstStatus: assert property (p_firstStatus) else $error("first status wrong");

  c_reachInit2: cover property (@(posedge clk) disable iff (srst)
    $rose(state_r == node_init_pkg::ST_SECOND_INIT_STATE));
  c_override: cover property (@(posedge clk) disable iff (srst) overrideAcc);
  c_conflict: cover property (@(posedge clk) disable iff (srst) conflict);
endmodule
`default_nettype wire

// File: tb/spi_ctrl_model.sv
// Controller model for the shared SPI link: framed 24-bit transfers, MSB first.
// Assumes one caller of frame() at a time; pins change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module spi_ctrl_model (
  // Clock.
  input  wire logic   clk,
  // SPI.
  input  wire logic   sdoWire,
  output logic        sclk,
  output logic        csN,
  output logic        sdi,
  // Result.
  output logic        done,
  output logic [23:0] rxWord
);
  int half = 2;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    done = 1'b0;
    rxWord = 24'h000000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // SDO is read as sclk rises, half a clk cycle short of a half period after the device last shifted.
  task automatic frame(input logic [23:0] tx);
    @(negedge clk);
    csN = 1'b0;
    repeat (half) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdi = tx[i];
      repeat (half) @(negedge clk);
      sclk = 1'b1;
      rxWord[i] = sdoWire;
      repeat (half) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge clk);
    csN = 1'b1;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    repeat (half) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/node_addr_init_tb_top.sv
// Self-checking bench for the node-address initialization block.
// Assumes the controller model drives SPI; SDO and the fault pin are resolved here.
`include "node_init_params.svh"
`timescale 1ns/10ps
`default_nettype none
module node_addr_init_tb_top;
  localparam int READY = 20;
  localparam logic [23:0] FULL = 24'h1FFFFF;
  logic clk = 1'b0, srst = 1'b1, hvUv = 1'b1, devErr = 1'b0, crcW = 1'b1, pullUp = 1'b1;
  logic en1 = 1'b1, en2 = 1'b1, otherDrive = 1'b0, idleBit = 1'b0, oeSeen = 1'b0;
  logic lsOv = 1'b0, lsUv = 1'b1;
  logic [1:0] senseCode = 2'h1, n, a;
  logic [15:0] d, prim;
  logic [23:0] rxWord;
  logic [47:0] expQ[$];
  logic faultOe, faultOut, sdoOut, sdoOe, addrErr, second_init_state, sclk, csN, sdi, done;
  logic [1:0] nodeAddress;
  wire sdoWire = otherDrive ? 1'b1 : (sdoOe ? sdoOut : idleBit);
  wire faultIn = faultOe ? faultOut : pullUp;
  int seed = 50, mismatches = 0, n_tests = 0, cnt;
  node_addr_init #(.READY_CYCLES(READY)) dut (.clk(clk), .srst(srst),
    .hvSupplyUndervoltage(hvUv), .logicSupplyOvervoltage(lsOv),
    .logicSupplyUndervoltage(lsUv), .deviceError(devErr), .configCrcWarning(crcW),
    .faultAddressPinIn(faultIn), .faultAddressPinOut(faultOut),
    .faultAddressPinOe(faultOe), .senseCode(senseCode), .enablePinOne(en1),
    .enablePinTwo(en2), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoIn(sdoWire),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .nodeAddress(nodeAddress),
    .nodeAddressError(addrErr), .secondInitState(second_init_state));
  spi_ctrl_model ctrl (.clk(clk), .sdoWire(sdoWire), .sclk(sclk), .csN(csN), .sdi(sdi),
    .done(done), .rxWord(rxWord));
  initial forever #10 clk = ~clk;
  // A released SDO wire toggles so that a stale bit never passes for an answer.
  always @(posedge clk) idleBit <= ~idleBit;
  always @(posedge clk) if (sdoOe === 1'b1) oeSeen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] rpl(input logic s, e, r, input logic [1:0] nd,
                                      input logic [15:0] dt);
    return {3'h0, s, e, r, nd, dt};
  endfunction
  function automatic logic [23:0] rd(input logic [1:0] nd, input logic [4:0] rg);
    return {1'b0, nd, rg, 16'h0000};
  endfunction
  function automatic logic [23:0] bc(input logic [1:0] nd, input logic [15:0] dt);
    return {1'b1, nd, `REG_BROADCAST, dt};
  endfunction
  task automatic checkWord(input string nm, input logic [23:0] m, e, s);
    n_tests++;
    if ((s & m) !== (e & m)) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask
  task automatic checkBit(input string nm, input logic [1:0] e, s);
    checkWord(nm, 24'h000003, {22'h0, e}, {22'h0, s});
  endtask
  // The reply of each frame travels in the next one, so the note names that reply.
  task automatic xfer(input logic [23:0] tx, m, v);
    expQ.push_back({m, v});
    ctrl.frame(tx);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge done) begin
    logic [47:0] e;
    e = expQ.pop_front();
    checkWord("reply", e[47:24], e[23:0], rxWord);
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ctrl.half = 2 + ($random(seed) & 1);
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (100) @(negedge clk);
    checkBit("second_init_state", 0, second_init_state);
    // Only the logic supply is still bad, so each logic-supply monitor must gate on its own.
    hvUv = 1'b0;
    xfer(rd(0, `REG_PRIMARY), 0, 0);
    xfer(rd(0, `REG_PRIMARY), FULL, rpl(1, 0, 1, 0, 16'hC000));
    senseCode = 2'($random(seed));
    en1 = 1'b1;
    en2 = 1'($random(seed));
    lsUv = 1'b0;
    lsOv = 1'b1;
    repeat (30) @(negedge clk);
    lsOv = 1'b0;
    cnt = 0;
    while (second_init_state !== 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    checkBit("readyTime", 1, cnt >= READY + `SENSE_CYCLES && cnt <= READY + 510);
    n = senseCode;
    checkBit("node", n, nodeAddress);
    prim = {1'b1, crcW, en1, en2, 12'h000};
    xfer(rd(n, `REG_PRIMARY), FULL, rpl(1, 0, 1, 0, 16'hF000));
    xfer(rd(n, `REG_SECONDARY), FULL, rpl(0, 0, 0, n, prim));
    d = {3'b001, ~n, 11'($random(seed))};
    xfer(bc(n, d), FULL, rpl(0, 0, 0, n, {en1, 15'h0000}));
    xfer(rd(n, `REG_PRIMARY), FULL, rpl(0, 0, 0, n, d));
    checkBit("node", n, nodeAddress);
    oeSeen <= 1'b0;
    xfer(rd(~n, `REG_PRIMARY), 0, 0);
    checkBit("silent", 0, oeSeen);
    pullUp = 1'b0;
    xfer(bc(n, 16'h4000), 0, 0);
    repeat (READY) @(negedge clk);
    xfer(bc(n, 16'h0000), 0, 0);
    settle();
    checkBit("second_init_state", 0, second_init_state);
    // A reinit request during sensing must be dropped, not kept for later.
    xfer(bc(n, 16'h4000), 0, 0);
    cnt = 0;
    while (second_init_state !== 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    checkBit("second_init_state", 1, second_init_state);
    checkBit("addrErr", 1, addrErr);
    checkBit("node", n, nodeAddress);
    xfer(bc(n, 16'h0000), 0, 0);
    settle();
    checkBit("second_init_state", 1, second_init_state);
    xfer(rd(n, `REG_PRIMARY), 0, 0);
    xfer(rd(n, `REG_PRIMARY), FULL, rpl(0, 1, 0, n, prim));
    a = 2'($random(seed));
    xfer(bc(n, {3'b001, a, 11'h000}), FULL, rpl(0, 1, 0, n, prim));
    settle();
    checkBit("node", a, nodeAddress);
    checkBit("addrErr", 0, addrErr);
    pullUp = 1'b1;
    n = a;
    xfer(bc(n, 16'h0000), 0, 0);
    xfer(rd(n, `REG_PRIMARY), FULL, rpl(0, 0, 0, n, 16'h0000));
    otherDrive = 1'b1;
    xfer(rd(n, `REG_PRIMARY), 0, 0);
    otherDrive = 1'b0;
    checkBit("addrErr", 1, addrErr);
    checkBit("sdoOe", 0, sdoOe);
    devErr = 1'b1;
    settle();
    checkBit("faultOe", 1, faultOe);
    checkBit("faultPin", 0, faultIn);
    oeSeen <= 1'b0;
    xfer(rd(n, `REG_PRIMARY), 0, 0);
    checkBit("silent", 0, oeSeen);
    complete_run();
  end
endmodule
`default_nettype wire
